// file: mbp_pwm_map.vh
// Constants shared by the match-based PWM unit
`ifndef MBP_PWM_MAP_VH
`define MBP_PWM_MAP_VH

// Counter width, match and output counts
`define MBP_CNT_W 32
`define MBP_NUM_MATCH 7
`define MBP_NUM_OUT 6

// Reset values and count step
`define MBP_COUNT_RST 32'h0000_0000
`define MBP_MATCH_RST 32'h0000_0000
`define MBP_COUNT_STEP 32'h0000_0001

// Count source selection
`define MBP_SRC_TIMER 2'h0
`define MBP_SRC_RISE 2'h1
`define MBP_SRC_FALL 2'h2
`define MBP_SRC_BOTH 2'h3

`endif

// file: mbp_match_slot.v
// One shadowed match register with release and apply handshake
`timescale 1ns/1ns
`include "mbp_pwm_map.vh"

module mbp_match_slot (
   input wire clk_sys,
   input wire reset_n,
   input wire [31:0] newValue,
   input wire releaseStrobe,
   input wire applyStrobe,
   output reg [31:0] activeValue,
   output reg pending
);

   reg [31:0] shadowReg;

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         shadowReg <= `MBP_MATCH_RST;
         activeValue <= `MBP_MATCH_RST;
         pending <= 1'h0;
      end else begin
         if (releaseStrobe) begin
            shadowReg <= newValue;
         end
         // Old shadow moves to active; a new release in the same cycle stays pending
         if (applyStrobe && pending) begin
            activeValue <= shadowReg;
         end
         pending <= releaseStrobe | (pending & ~applyStrobe);
      end
   end

endmodule

// file: mbp_pwm_unit.v
// Match-based PWM unit: prescaled 32-bit counter, seven match slots, six outputs
//
// Operation
// - Period match resets count, fixing shared period
// - Single-edge outputs rise at cycle start, fall on match
// - Double-edge outputs use separate rise and fall matches
// - Rise first gives positive, fall first negative
// - Seven match registers shared by all outputs
// - Each match may reset, stop, or flag
// - Count peripheral clock or capture input transitions
// - 32-bit counter behind 32-bit prescaler
// - New match values used only after release
// - Period and width any tick count, one rate
// - Modulation off gives plain timer, outputs low
`timescale 1ns/1ns
`include "mbp_pwm_map.vh"

module mbp_pwm_unit (
   input wire clk_sys,
   input wire reset_n,
   input wire counterEnable,
   input wire counterClear,
   input wire pwmModeEn,
   input wire [1:0] countSource,
   input wire captureSelect,
   input wire capturePin0,
   input wire capturePin1,
   input wire [31:0] prescaleLimit,
   input wire [31:0] cyclePeriodMatch,
   input wire [31:0] matchValue1,
   input wire [31:0] matchValue2,
   input wire [31:0] matchValue3,
   input wire [31:0] matchValue4,
   input wire [31:0] matchValue5,
   input wire [31:0] matchValue6,
   input wire [6:0] matchRelease,
   input wire [6:0] matchResetEn,
   input wire [6:0] matchStopEn,
   input wire [6:0] matchIrqEn,
   input wire [6:2] doubleEdgeSel,
   input wire [6:1] outputEnable,
   output reg [6:1] pwmOut,
   output reg [31:0] timerCount,
   output reg [31:0] prescaleCount,
   output reg [6:0] matchIrq,
   output wire [6:0] releasePending,
   output reg counterStopped
);

   // Capture pin synchronisers plus one stage for edge detection
   reg [1:0] capSync1Reg;
   reg [1:0] capSync2Reg;
   reg [1:0] capPrevReg;
   // Pin edges ignored until the synchroniser has filled
   reg [2:0] capFillReg;
   reg srcTick;
   reg [6:1] pwmNext;
   reg setEv;
   reg clrEv;
   integer n;

   wire [223:0] allValues;
   wire [223:0] activeValues;
   wire [6:0] matchHit;
   wire [6:0] edgeHit;
   wire [6:1] dblSel;
   wire capNow;
   wire capOld;
   wire run;
   wire presDone;
   wire countMoves;
   wire periodHit;
   wire capReady;
   wire resetHit;
   wire stopHit;
   wire cycleStart;
   wire applyStrobe;
   wire [31:0] countInc;
   wire [31:0] countNext;

   assign allValues = {matchValue6, matchValue5, matchValue4, matchValue3,
      matchValue2, matchValue1, cyclePeriodMatch};
   assign dblSel = {doubleEdgeSel, 1'h0};

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         capSync1Reg <= 2'h0;
         capSync2Reg <= 2'h0;
         capPrevReg <= 2'h0;
         capFillReg <= 3'h0;
      end else begin
         capSync1Reg <= {capturePin1, capturePin0};
         capSync2Reg <= capSync1Reg;
         capPrevReg <= capSync2Reg;
         capFillReg <= {capFillReg[1:0], 1'h1};
      end
   end

   assign capNow = capSync2Reg[captureSelect];
   assign capOld = capPrevReg[captureSelect];
   assign capReady = capFillReg[2];

   // Count source: every clock, or chosen edges of the capture input
   always @* begin
      case (countSource)
         `MBP_SRC_TIMER: srcTick = 1'h1;
         `MBP_SRC_RISE: srcTick = capReady & capNow & ~capOld;
         `MBP_SRC_FALL: srcTick = capReady & ~capNow & capOld;
         `MBP_SRC_BOTH: srcTick = capReady & (capNow ^ capOld);
         default: srcTick = 1'h0;
      endcase
   end

   assign run = counterEnable & ~counterStopped;
   // A clear on the same edge overrides any match action
   assign presDone = run & srcTick & ~counterClear & (prescaleCount == prescaleLimit);

   // Match slots, one per register
   genvar i;
   generate
      for (i = 0; i < `MBP_NUM_MATCH; i = i + 1) begin : gSlot
         mbp_match_slot uSlot (
            .clk_sys(clk_sys),
            .reset_n(reset_n),
            .newValue(allValues[i*32 +: 32]),
            .releaseStrobe(matchRelease[i]),
            .applyStrobe(applyStrobe),
            .activeValue(activeValues[i*32 +: 32]),
            .pending(releasePending[i])
         );
         assign matchHit[i] = (activeValues[i*32 +: 32] == timerCount);
         // Edges compare against the count about to be loaded
         assign edgeHit[i] = presDone & countMoves & (activeValues[i*32 +: 32] == countNext);
      end
   endgenerate

   // Period match always restarts the cycle while modulating
   assign periodHit = pwmModeEn & matchHit[0];
   assign resetHit = |(matchHit & matchResetEn) | periodHit;
   assign stopHit = |(matchHit & matchStopEn);
   assign cycleStart = presDone & periodHit;

   // Shadow values wait for the cycle boundary while modulating
   assign applyStrobe = pwmModeEn ? cycleStart : 1'h1;

   assign countInc = timerCount + `MBP_COUNT_STEP;
   assign countNext = resetHit ? `MBP_COUNT_RST : countInc;
   // A stop without reset holds the count, so no edge may fire
   assign countMoves = resetHit | ~stopHit;

   // Prescaler and main counter
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         prescaleCount <= `MBP_COUNT_RST;
         timerCount <= `MBP_COUNT_RST;
      end else begin
         if (counterClear) begin
            prescaleCount <= `MBP_COUNT_RST;
            timerCount <= `MBP_COUNT_RST;
         end else if (run && srcTick) begin
            if (presDone) begin
               prescaleCount <= `MBP_COUNT_RST;
               if (resetHit) begin
                  timerCount <= `MBP_COUNT_RST;
               end else if (!stopHit) begin
                  timerCount <= countInc;
               end
            end else begin
               prescaleCount <= prescaleCount + `MBP_COUNT_STEP;
            end
         end
      end
   end

   // Stop flag and match pulses
   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         counterStopped <= 1'h0;
         matchIrq <= 7'h00;
      end else begin
         // Halt holds until software drops the enable
         if (!counterEnable) begin
            counterStopped <= 1'h0;
         end else if (presDone && stopHit) begin
            counterStopped <= 1'h1;
         end
         matchIrq <= presDone ? (matchHit & matchIrqEn) : 7'h00;
      end
   end

   // Output edges; a clear on the same tick as a set wins
   always @* begin
      pwmNext = pwmOut;
      setEv = 1'h0;
      clrEv = 1'h0;
      for (n = 1; n <= `MBP_NUM_OUT; n = n + 1) begin
         if (dblSel[n]) begin
            setEv = edgeHit[n-1];
         end else begin
            setEv = cycleStart;
         end
         clrEv = edgeHit[n];
         if (!pwmModeEn || !outputEnable[n]) begin
            pwmNext[n] = 1'h0;
         end else if (clrEv) begin
            pwmNext[n] = 1'h0;
         end else if (setEv) begin
            pwmNext[n] = 1'h1;
         end
      end
   end

   always @(posedge clk_sys or negedge reset_n) begin
      if (!reset_n) begin
         pwmOut <= 6'h00;
      end else begin
         pwmOut <= pwmNext;
      end
   end

endmodule

// file: mbp_pwm_unit_properties.sv
// Assertion checker for the match-based PWM unit
`timescale 1ns/1ns
module mbp_pwm_unit_chk (
   input logic clk_sys,
   input logic reset_n,
   input logic counterEnable,
   input logic counterClear,
   input logic pwmModeEn,
   input logic [6:0] matchRelease,
   input logic [6:0] matchIrqEn,
   input logic [6:1] outputEnable,
   input logic [6:1] pwmOut,
   input logic [31:0] timerCount,
   input logic [31:0] prescaleCount,
   input logic [6:0] matchIrq,
   input logic [6:0] releasePending,
   input logic counterStopped
);
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!reset_n);
   chk_clear_zero: assert property (counterClear |=> !timerCount && !prescaleCount)
      else $error("clear");
   chk_idle_hold: assert property (!counterEnable && !counterClear |=> $stable(timerCount))
      else $error("idle");
   chk_timer_mode: assert property (!pwmModeEn |=> !pwmOut)
      else $error("timer");
   chk_out_off: assert property (!outputEnable |=> !pwmOut)
      else $error("enable");
   chk_irq_cause: assert property (matchIrq[0] |-> $past(matchIrqEn[0]))
      else $error("irq");
   chk_release_pend: assert property (matchRelease[1] |=> releasePending[1])
      else $error("pending");
   chk_stop_hold: assert property (counterStopped && !counterClear |=> $stable(timerCount))
      else $error("stop");
   chk_stop_clear: assert property (!counterEnable |=> !counterStopped)
      else $error("restart");
   cov_irq: cover property (matchIrq[0]);
   cov_rise: cover property ($rose(pwmOut[1]));
   cov_stop: cover property (counterStopped);
endmodule
bind mbp_pwm_unit mbp_pwm_unit_chk chk (.*);

// file: mbp_pwm_unit_tb_top.sv
// Testbench for the match-based PWM unit
`timescale 1ns/1ns
module mbp_pwm_unit_tb_top;
   logic clk_sys, reset_n, counterEnable, counterClear, pwmModeEn, captureSelect;
   logic capturePin0, capturePin1, counterStopped;
   logic [1:0] countSource;
   logic [31:0] prescaleLimit, cyclePeriodMatch, matchValue1, matchValue2, matchValue3;
   logic [31:0] matchValue4, matchValue5, matchValue6, timerCount, prescaleCount;
   logic [6:0] matchRelease, matchResetEn, matchStopEn, matchIrqEn, matchIrq, releasePending;
   logic [6:2] doubleEdgeSel;
   logic [6:1] outputEnable, pwmOut;
   int fail_count = 0;
   int n_compared = 0;
   mbp_pwm_unit uut (.*);
   initial begin
      clk_sys = 0;
      forever #5 clk_sys = ~clk_sys;
   end
   task chk(input string n, input logic [31:0] s, e);
      n_compared++;
      if (s !== e) begin
         fail_count++;
         $display("BAD %s exp %0h got %0h", n, e, s);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask
   // Counts high cycles of outputs 1 and 2
   task meas(input int w, output int h1, h2);
      h1 = 0;
      h2 = 0;
      repeat (w) begin
         tick(1);
         h1 += pwmOut[1];
         h2 += pwmOut[2];
      end
   endtask
   task cfg(input logic [31:0] pl, p, a, b);
      int i;
      @(posedge clk_sys);
      {prescaleLimit, cyclePeriodMatch, matchValue1, matchValue2} <= {pl, p, a, b};
      {matchValue3, matchValue4, matchValue5, matchValue6} <= {4{b}};
      matchRelease <= 7'h7F;
      @(posedge clk_sys);
      matchRelease <= 7'h00;
      #1;
      chk("pending", releasePending, 7'h7F);
      for (i = 0; i < 100 && releasePending !== 0; i++)
         tick(1);
      chk("applied", releasePending, 0);
      tick(2 * (p + 1) * (pl + 1));
   endtask
   task t_timer;
      int k;
      @(posedge clk_sys);
      {matchResetEn, matchIrqEn, counterEnable} <= {7'h01, 7'h01, 1'b1};
      cfg(0, 2, 0, 0);
      @(posedge clk_sys);
      counterClear <= 1;
      @(posedge clk_sys);
      counterClear <= 0;
      for (k = 1; k < 7; k++) begin
         tick(1);
         chk("count", timerCount, k % 3);
         chk("irq", matchIrq, (k % 3 == 0) ? 7'h01 : 7'h00);
         chk("out", pwmOut, 0);
      end
      @(posedge clk_sys);
      matchStopEn <= 7'h01;
      tick(6);
      chk("stopped", counterStopped, 1);
      chk("held", timerCount, 0);
      @(posedge clk_sys);
      {counterEnable, matchStopEn} <= '0;
      tick(2);
      chk("restart", counterStopped, 0);
   endtask
   task t_pwm;
      int h1, h2;
      @(posedge clk_sys);
      {counterEnable, pwmModeEn, matchResetEn, outputEnable} <= {2'h3, 7'h00, 6'h03};
      cfg(1, 9, 4, 0);
      meas(20, h1, h2);
      chk("single", h1, 8);
      chk("low", h2, 0);
      @(posedge clk_sys);
      doubleEdgeSel <= 5'h01;
      cfg(0, 9, 2, 6);
      meas(10, h1, h2);
      chk("width", h1, 2);
      chk("pos", h2, 4);
      cfg(0, 9, 6, 2);
      meas(10, h1, h2);
      chk("width2", h1, 6);
      chk("neg", h2, 6);
   endtask
   // Toggles one capture pin cnt times, four clocks per level
   task toggle(input logic sel, input int cnt);
      repeat (cnt) begin
         @(posedge clk_sys);
         if (sel)
            capturePin1 <= ~capturePin1;
         else
            capturePin0 <= ~capturePin0;
         tick(3);
      end
   endtask
   task t_capture;
      @(posedge clk_sys);
      {pwmModeEn, outputEnable, countSource, captureSelect} <= {1'h0, 6'h00, 2'h1, 1'h1};
      {prescaleLimit, counterClear} <= {32'h1, 1'h1};
      @(posedge clk_sys);
      counterClear <= 1'h0;
      toggle(1'h1, 8);
      chk("rise count", timerCount, 2);
      chk("prescale", prescaleCount, 0);
      toggle(1'h0, 2);
      chk("other pin", timerCount, 2);
      @(posedge clk_sys);
      {countSource, prescaleLimit} <= {2'h3, 32'h0};
      toggle(1'h1, 3);
      chk("both count", timerCount, 5);
      @(posedge clk_sys);
      {countSource, captureSelect} <= {2'h2, 1'h0};
      toggle(1'h0, 4);
      chk("fall count", timerCount, 7);
      @(posedge clk_sys);
      {countSource, matchStopEn} <= {2'h0, 7'h01};
      tick(5);
      chk("stop count", timerCount, 9);
      chk("stop flag", counterStopped, 1);
   endtask
   task test_done;
      $display("compared %0d failed %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      {reset_n, counterEnable, counterClear, pwmModeEn, captureSelect, capturePin0} = '0;
      {capturePin1, countSource, matchRelease, matchResetEn, matchStopEn, matchIrqEn} = '0;
      {doubleEdgeSel, outputEnable, prescaleLimit, cyclePeriodMatch, matchValue1} = '0;
      {matchValue2, matchValue3, matchValue4, matchValue5, matchValue6} = '0;
      repeat (12) @(posedge clk_sys);
      reset_n <= 1;
      t_timer;
      t_pwm;
      t_capture;
      test_done;
   end
   initial begin
      #100000;
      fail_count++;
      test_done;
   end
endmodule
